// ### dscc_channel.sv
`timescale 1ns/1ns
`default_nettype none
module dscc_channel (
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  input  wire logic                         start,
  input  wire dscc_pkg::dscc_move_t         move_kind,
  input  wire logic [dscc_pkg::MAG_W-1:0]   steps,
  input  wire logic                         dir_cw,
  input  wire logic                         estop,
  input  wire logic                         dstop,
  input  wire logic                         clear_pos,
  input  wire dscc_pkg::dscc_cfg_t          cfg,
  input  wire dscc_pkg::dscc_switch_t       sw,
  output logic                              busy,
  output logic                              step_out,
  output logic                              dir_out,
  output logic [dscc_pkg::SW_N-1:0]         limit_hit,
  output logic [dscc_pkg::MAG_W-1:0]        remaining,
  output logic signed [dscc_pkg::STEP_W-1:0] position
);
  import dscc_pkg::*;

  logic [PARAM_W-1:0] period_reg;
  logic [PARAM_W-1:0] timer_reg;
  logic [PARAM_W-1:0] accel_reg;
  logic               decel_reg;
  dscc_move_t         kind_reg;
  logic [PARAM_W-1:0] period_next;
  logic [PARAM_W:0]   slower;
  logic               end_hit, inner_hit, tick, counted, target_hit, hard_stop, halt, step_ok, speed_up;

  assign end_hit    = sw.end_travel_limit_first | sw.end_travel_limit_second;
  assign inner_hit  = sw.inner_limit_first | sw.inner_limit_second;
  assign tick       = busy && (timer_reg == '0);
  assign counted    = (kind_reg == MV_JOG) || (kind_reg == MV_RAMP) || (kind_reg == MV_CONST);
  assign target_hit = ((kind_reg == MV_HOME) && sw.home_switch) || ((kind_reg == MV_TO_INNER) && inner_hit);
  assign hard_stop  = busy && (estop || end_hit || target_hit);
  assign step_ok    = tick && !hard_stop;
  assign halt       = hard_stop || (step_ok && counted && remaining == 24'h000001) ||
                      (step_ok && decel_reg && period_reg >= cfg.start_period);
  assign slower     = {1'b0, period_reg} + {1'b0, cfg.rate_step};
  assign speed_up   = (kind_reg == MV_RAMP) && (accel_reg < cfg.ramp_steps) && (period_reg > cfg.run_period);

  // slow start, ramp up, ramp down before end
  always_comb begin
    period_next = period_reg;
    if (decel_reg || ((kind_reg == MV_RAMP) && (remaining <= {8'h00, accel_reg}))) begin
      period_next = (slower > {1'b0, cfg.start_period}) ? cfg.start_period : slower[PARAM_W-1:0];
    end else if (speed_up) begin
      period_next = (period_reg - cfg.run_period > cfg.rate_step) ? period_reg - cfg.rate_step : cfg.run_period;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy <= 1'b0;
    end else if (start && !busy) begin
      busy <= 1'b1;
    end else if (halt) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      period_reg <= '0;
      timer_reg  <= '0;
      accel_reg  <= '0;
      decel_reg  <= 1'b0;
      kind_reg   <= MV_JOG;
      dir_out    <= 1'b0;
    end else if (start && !busy) begin
      kind_reg   <= move_kind;
      dir_out    <= dir_cw;
      period_reg <= (move_kind == MV_TO_END) ? cfg.run_period : cfg.start_period;
      timer_reg  <= (move_kind == MV_TO_END) ? cfg.run_period - 16'h0001 : cfg.start_period - 16'h0001;
      accel_reg  <= '0;
      decel_reg  <= 1'b0;
    end else if (busy) begin
      if (dstop || (inner_hit && (kind_reg == MV_RAMP || kind_reg == MV_CONST))) begin
        decel_reg <= 1'b1;
      end
      if (tick) begin
        period_reg <= period_next;
        timer_reg  <= period_next - 16'h0001;
        if (speed_up && !decel_reg) begin
          accel_reg <= accel_reg + 16'h0001;
        end
      end else begin
        timer_reg <= timer_reg - 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      step_out  <= 1'b0;
      remaining <= '0;
      position  <= '0;
      limit_hit <= '0;
    end else begin
      step_out <= step_ok;
      if (clear_pos || (busy && kind_reg == MV_HOME && sw.home_switch)) begin
        position <= '0;
      end else if (step_ok) begin
        position <= dir_out ? position + 32'sh00000001 : position - 32'sh00000001;
      end
      if (start && !busy) begin
        remaining <= steps;
        limit_hit <= '0;
      end else begin
        if (step_ok && counted && remaining != '0) begin
          remaining <= remaining - 24'h000001;
        end
        if (busy) begin
          limit_hit <= limit_hit | sw;
        end
      end
    end
  end

  chk_estop_halts: assert property (@(posedge core_clk) disable iff (reset)
    busy && estop |=> !busy && !step_out) else $error("emergency stop did not halt pulses");
  chk_end_limit_stop: assert property (@(posedge core_clk) disable iff (reset)
    busy && end_hit |=> !busy ##1 !step_out) else $error("end limit did not stop motor");
  chk_home_zero: assert property (@(posedge core_clk) disable iff (reset)
    busy && kind_reg == MV_HOME && sw.home_switch |=> position == 32'sh00000000 && !busy)
    else $error("home switch did not zero position");
  chk_dir_latched: assert property (@(posedge core_clk) disable iff (reset)
    start && !busy |=> dir_out == $past(dir_cw) && busy) else $error("direction not taken from sign");

endmodule // dscc_channel
`default_nettype wire

// ### dscc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module dscc_checker (
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic                          cmd_valid,
  input  wire dscc_pkg::dscc_cmd_t           cmd,
  input  wire logic                          hw_ready,
  input  wire dscc_pkg::dscc_switch_t        switches [dscc_pkg::CHAN_N],
  output logic                               result_valid,
  output logic [dscc_pkg::CODE_W-1:0]        result_code,
  output logic                               status_valid,
  output dscc_pkg::dscc_status_t             status_out,
  output logic [dscc_pkg::CHAN_N-1:0]        step_pulse,
  output logic [dscc_pkg::CHAN_N-1:0]        step_dir_cw,
  output logic [dscc_pkg::CHAN_N-1:0]        chan_busy,
  output logic [dscc_pkg::CHAN_N-1:0]        chan_ready
);
  import dscc_pkg::*;

  logic [CHAN_N-1:0]        start_reg;
  logic [CHAN_N-1:0]        estop_reg;
  logic [CHAN_N-1:0]        dstop_reg;
  logic [CHAN_N-1:0]        clear_reg;
  dscc_move_t               kind_reg;
  logic [MAG_W-1:0]         steps_reg;
  logic                     dir_reg;
  dscc_cfg_t                cfg_reg     [CHAN_N];
  logic [LASTOP_W-1:0]      last_op_reg [CHAN_N];
  logic [SW_N-1:0]          hit_w       [CHAN_N];
  logic [MAG_W-1:0]         remain_w    [CHAN_N];
  logic signed [STEP_W-1:0] pos_w       [CHAN_N];

  logic signed [OP_W-1:0]    op;
  logic signed [STEP_W-1:0]  step_cnt;
  logic signed [STEP_W-1:0]  step_abs;
  logic signed [PARAM_W-1:0] p1, p2, p3, p4;
  logic                      op_ok, chan_ok, ch, ch_busy, is_motion, is_stop, step_bad;
  logic [CODE_W-1:0]         code_next;
  logic                      accept;
  logic                      no_move;
  dscc_move_t                kind_next;

  assign op       = cmd.operation_select;
  assign step_cnt = cmd.signed_step_count;
  assign step_abs = step_cnt[STEP_W-1] ? -step_cnt : step_cnt;
  assign p1       = cmd.param[1];
  assign p2       = cmd.param[2];
  assign p3       = cmd.param[3];
  assign p4       = cmd.param[4];
  assign op_ok    = (op >= OP_ESTOP) && (op <= OP_INIT);
  // element zero is the channel select
  assign chan_ok  = (cmd.param[0] == CHAN_A_SEL) || (cmd.param[0] == CHAN_B_SEL);
  assign ch       = cmd.param[0][0];
  // per-channel busy, including a start not yet seen by the channel
  assign ch_busy   = chan_busy[ch] | start_reg[ch];
  assign is_motion = (op >= OP_JOG) && (op <= OP_HOME);
  assign is_stop   = (op == OP_ESTOP) || (op == OP_DSTOP);
  assign step_bad  = ((op == OP_RAMP) || (op == OP_CONST)) && ((step_cnt > STEP_LIMIT) || (step_cnt < -STEP_LIMIT));

  // every check resolves before any motion output
  always_comb begin
    code_next = RES_OK;
    if (!op_ok) begin
      code_next = RES_BAD_OP;
    end else if (!chan_ok) begin
      // element n maps to 10 + n
      code_next = RES_PARAM_BASE;
    end else if ((op != OP_INIT) && !chan_ready[ch]) begin
      code_next = ch ? RES_NOINIT_B : RES_NOINIT_A;
    end else if (!hw_ready) begin
      code_next = RES_HW_ERR;
    end else if (step_bad) begin
      code_next = RES_STEP_RANGE;
    end else if ((is_motion || op == OP_INIT) && ch_busy) begin
      code_next = RES_BUSY;
    // stop of an idle motor is redundant
    end else if (is_stop && !ch_busy) begin
      code_next = RES_STANDSTILL;
    end else if (op == OP_INIT) begin
      if (p1 < MIN_PERIOD) begin
        code_next = RES_PARAM_1;
      end else if ((p2 < MIN_PERIOD) || (p2 > p1)) begin
        code_next = RES_PARAM_2;
      end else if (p3 < 16'sh0001) begin
        code_next = RES_PARAM_3;
      end else if (p4 < 16'sh0000) begin
        code_next = RES_PARAM_4;
      end
    end
  end

  assign accept = cmd_valid && (code_next == RES_OK);

  // motion operations mapped to move kinds
  always_comb begin
    kind_next = MV_JOG;
    no_move   = 1'b0;
    unique case (op)
      OP_RAMP: begin
        kind_next = (step_abs == 32'sh00000001) ? MV_JOG : MV_RAMP;
        no_move   = (step_abs == 32'sh00000000);
      end
      OP_CONST: begin
        kind_next = (step_abs == 32'sh00000001) ? MV_JOG : MV_CONST;
        no_move   = (step_abs == 32'sh00000000);
      end
      OP_TO_INNER: kind_next = MV_TO_INNER;
      OP_TO_END:   kind_next = MV_TO_END;
      OP_HOME:     kind_next = MV_HOME;
      default:     kind_next = MV_JOG;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      result_valid <= 1'b0;
      result_code  <= RES_OK;
    end else begin
      result_valid <= cmd_valid;
      if (cmd_valid) begin
        result_code <= code_next;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      start_reg <= '0;
      estop_reg <= '0;
      dstop_reg <= '0;
      clear_reg <= '0;
      kind_reg  <= MV_JOG;
      steps_reg <= '0;
      dir_reg   <= 1'b0;
    end else begin
      start_reg <= '0;
      estop_reg <= '0;
      dstop_reg <= '0;
      clear_reg <= '0;
      if (accept) begin
        start_reg[ch] <= is_motion && !no_move;
        estop_reg[ch] <= (op == OP_ESTOP);
        dstop_reg[ch] <= (op == OP_DSTOP);
        clear_reg[ch] <= (op == OP_INIT);
        kind_reg      <= kind_next;
        steps_reg     <= (op == OP_JOG || step_abs == 32'sh00000001) ? 24'h000001 :
                         (op == OP_RAMP || op == OP_CONST) ? step_abs[MAG_W-1:0] : 24'h000000;
        // zero or positive count turns clockwise
        dir_reg       <= !step_cnt[STEP_W-1];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_valid <= 1'b0;
      status_out   <= '0;
    end else begin
      status_valid <= accept && (op == OP_STATUS);
      // status snapshot of the selected channel
      if (accept && (op == OP_STATUS)) begin
        status_out.limit_hit <= hit_w[ch];
        status_out.remaining <= remain_w[ch];
        status_out.last_op   <= last_op_reg[ch];
        status_out.position  <= pos_w[ch];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CHAN_N; gi++) begin : g_chan
      always_ff @(posedge core_clk) begin
        if (reset) begin
          chan_ready[gi]  <= 1'b0;
          cfg_reg[gi]     <= '{CFG_RESET, CFG_RESET, CFG_RESET, CFG_RESET};
          last_op_reg[gi] <= '0;
        end else if (accept && (ch == 1'(gi))) begin
          if (op == OP_INIT) begin
            chan_ready[gi] <= 1'b1;
            cfg_reg[gi]    <= '{cmd.param[1], cmd.param[2], cmd.param[3], cmd.param[4]};
          end
          if (is_motion || is_stop) begin
            last_op_reg[gi] <= op[LASTOP_W-1:0];
          end
        end
      end

      dscc_channel u_channel (
        .core_clk  (core_clk),
        .reset     (reset),
        .start     (start_reg[gi]),
        .move_kind (kind_reg),
        .steps     (steps_reg),
        .dir_cw    (dir_reg),
        .estop     (estop_reg[gi]),
        .dstop     (dstop_reg[gi]),
        .clear_pos (clear_reg[gi]),
        .cfg       (cfg_reg[gi]),
        .sw        (switches[gi]),
        .busy      (chan_busy[gi]),
        .step_out  (step_pulse[gi]),
        .dir_out   (step_dir_cw[gi]),
        .limit_hit (hit_w[gi]),
        .remaining (remain_w[gi]),
        .position  (pos_w[gi])
      );
    end
  endgenerate

  chk_result_timing: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid |=> result_valid) else $error("command got no result next cycle");
  chk_error_no_action: assert property (@(posedge core_clk) disable iff (reset)
    result_valid && result_code != RES_OK |-> start_reg == '0 && estop_reg == '0 && dstop_reg == '0)
    else $error("refused command still acted");
  chk_bad_op: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && (op < OP_ESTOP || op > OP_INIT) |=> result_code == RES_BAD_OP)
    else $error("out of range operation not reported");
  chk_chan_select: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && op_ok && cmd.param[0] > CHAN_B_SEL |=> result_code == RES_PARAM_BASE)
    else $error("bad channel select not reported");
  chk_noinit_code: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && op_ok && chan_ok && op != OP_INIT && !chan_ready[ch]
    |=> result_code == (ch ? RES_NOINIT_B : RES_NOINIT_A)) else $error("uninitialized channel not reported");
  chk_busy_refuse: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && is_motion && chan_ok && chan_ready[ch] && hw_ready && !step_bad && ch_busy
    |=> result_code == RES_BUSY && start_reg == '0) else $error("busy channel accepted a move");
  chk_step_range: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && op == OP_RAMP && chan_ok && chan_ready[ch] && hw_ready && step_cnt > STEP_LIMIT
    |=> result_code == RES_STEP_RANGE) else $error("step count range not enforced");
  chk_idle_stop: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && is_stop && chan_ok && chan_ready[ch] && hw_ready && !ch_busy
    |=> result_code == RES_STANDSTILL) else $error("stop of idle motor not reported");
  chk_code_gap: assert property (@(posedge core_clk) disable iff (reset)
    result_valid |-> result_code != RES_UNUSED_LO && result_code != RES_UNUSED_HI)
    else $error("unused result code issued");
  chk_init_first: assert property (@(posedge core_clk) disable iff (reset)
    (start_reg & ~chan_ready) == '0) else $error("move started on uninitialized channel");
  chk_hw_error: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && op_ok && chan_ok && (op == OP_INIT || chan_ready[ch]) && !hw_ready
    |=> result_code == RES_HW_ERR && start_reg == '0) else $error("hardware error not reported");
  chk_status_pulse: assert property (@(posedge core_clk) disable iff (reset)
    status_valid |-> result_valid && result_code == RES_OK) else $error("status without accepted read");
  chk_init_param: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && op == OP_INIT && chan_ok && hw_ready && !ch_busy && p1 < MIN_PERIOD
    |=> result_code == RES_PARAM_1) else $error("bad start period not reported");

  cov_dstop_busy: cover property (@(posedge core_clk) disable iff (reset)
    dstop_reg[0] && chan_busy[0]);

  cov_busy_retry: cover property (@(posedge core_clk) disable iff (reset)
    result_valid && result_code == RES_BUSY ##[1:50] result_valid && result_code == RES_OK);
  cov_ramp_done: cover property (@(posedge core_clk) disable iff (reset)
    start_reg[0] && kind_reg == MV_RAMP ##[1:1000] !chan_busy[0]);
  cov_init_b: cover property (@(posedge core_clk) disable iff (reset)
    clear_reg[1]);
  cov_status_hit: cover property (@(posedge core_clk) disable iff (reset)
    status_valid && status_out.limit_hit != '0);

endmodule // dscc_checker
`default_nettype wire

// ### dscc_motor_model.sv
`timescale 1ns/1ns
`default_nettype none
module dscc_motor_model #(parameter int LIM = 40, parameter int INNER = 30) (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic [dscc_pkg::CHAN_N-1:0] step_pulse,
  input  wire logic [dscc_pkg::CHAN_N-1:0] step_dir_cw,
  output dscc_pkg::dscc_switch_t           switches [dscc_pkg::CHAN_N],
  output int                               pos [dscc_pkg::CHAN_N]
);
  import dscc_pkg::*;
  // shaft position follows every step in its direction
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < CHAN_N; i++) begin
      if (reset) pos[i] <= 0;
      else if (step_pulse[i]) pos[i] <= step_dir_cw[i] ? pos[i] + 1 : pos[i] - 1;
    end
  end
  // end stop closes once the carriage reaches it
  always_comb begin
    for (int i = 0; i < CHAN_N; i++) begin
      switches[i] = '0;
      switches[i].end_travel_limit_first = (pos[i] >= LIM);
      // inner stop sits before the end stop, home marks shaft position zero
      switches[i].inner_limit_first = (pos[i] >= INNER);
      switches[i].home_switch = (pos[i] == 0);
    end
  end
endmodule // dscc_motor_model
`default_nettype wire

// ### dscc_pkg.sv
`default_nettype none
package dscc_pkg;

  localparam int OP_W    = 16;
  localparam int PARAM_W = 16;
  localparam int PARAM_N = 10;
  localparam int STEP_W  = 32;
  localparam int MAG_W   = 24;
  localparam int CODE_W  = 5;
  localparam int CHAN_N  = 2;
  localparam int SW_N    = 5;
  localparam int LASTOP_W = 4;

  // operation codes
  localparam logic signed [OP_W-1:0] OP_ESTOP     = 16'sh0000;
  localparam logic signed [OP_W-1:0] OP_DSTOP     = 16'sh0001;
  localparam logic signed [OP_W-1:0] OP_JOG       = 16'sh0002;
  localparam logic signed [OP_W-1:0] OP_RAMP      = 16'sh0003;
  localparam logic signed [OP_W-1:0] OP_CONST     = 16'sh0004;
  localparam logic signed [OP_W-1:0] OP_TO_INNER  = 16'sh0005;
  localparam logic signed [OP_W-1:0] OP_TO_END    = 16'sh0006;
  localparam logic signed [OP_W-1:0] OP_HOME      = 16'sh0007;
  localparam logic signed [OP_W-1:0] OP_STATUS    = 16'sh0008;
  localparam logic signed [OP_W-1:0] OP_ENCODER   = 16'sh0009;
  localparam logic signed [OP_W-1:0] OP_DIVIDER   = 16'sh000A;
  localparam logic signed [OP_W-1:0] OP_IRQ       = 16'sh000B;
  localparam logic signed [OP_W-1:0] OP_INIT      = 16'sh000C;

  // result codes
  localparam logic [CODE_W-1:0] RES_OK         = 5'h00;
  localparam logic [CODE_W-1:0] RES_BUSY       = 5'h01;
  localparam logic [CODE_W-1:0] RES_NOINIT_A   = 5'h02;
  localparam logic [CODE_W-1:0] RES_NOINIT_B   = 5'h03;
  localparam logic [CODE_W-1:0] RES_BAD_OP     = 5'h04;
  localparam logic [CODE_W-1:0] RES_HW_ERR     = 5'h05;
  localparam logic [CODE_W-1:0] RES_STEP_RANGE = 5'h06;
  localparam logic [CODE_W-1:0] RES_STANDSTILL = 5'h07;
  localparam logic [CODE_W-1:0] RES_UNUSED_LO  = 5'h08;
  localparam logic [CODE_W-1:0] RES_UNUSED_HI  = 5'h09;
  localparam logic [CODE_W-1:0] RES_PARAM_BASE = 5'h0A;
  localparam logic [CODE_W-1:0] RES_PARAM_1    = 5'h0B;
  localparam logic [CODE_W-1:0] RES_PARAM_2    = 5'h0C;
  localparam logic [CODE_W-1:0] RES_PARAM_3    = 5'h0D;
  localparam logic [CODE_W-1:0] RES_PARAM_4    = 5'h0E;

  localparam logic signed [STEP_W-1:0]  STEP_LIMIT  = 32'sh00FFFFFF;
  localparam logic signed [PARAM_W-1:0] MIN_PERIOD  = 16'sh0002;
  localparam logic [PARAM_W-1:0]        CHAN_A_SEL  = 16'h0000;
  localparam logic [PARAM_W-1:0]        CHAN_B_SEL  = 16'h0001;
  localparam logic [PARAM_W-1:0]        CFG_RESET   = 16'h0000;

  typedef enum logic [2:0] {MV_JOG, MV_RAMP, MV_CONST, MV_TO_INNER, MV_TO_END, MV_HOME} dscc_move_t;

  typedef struct packed {
    logic signed [OP_W-1:0]            operation_select;
    logic [PARAM_N-1:0][PARAM_W-1:0]   param;
    logic signed [STEP_W-1:0]          signed_step_count;
  } dscc_cmd_t;

  typedef struct packed {
    logic home_switch;
    logic inner_limit_second;
    logic inner_limit_first;
    logic end_travel_limit_second;
    logic end_travel_limit_first;
  } dscc_switch_t;

  typedef struct packed {
    logic [PARAM_W-1:0] start_period;
    logic [PARAM_W-1:0] run_period;
    logic [PARAM_W-1:0] rate_step;
    logic [PARAM_W-1:0] ramp_steps;
  } dscc_cfg_t;

  typedef struct packed {
    logic [SW_N-1:0]          limit_hit;
    logic [MAG_W-1:0]         remaining;
    logic [LASTOP_W-1:0]      last_op;
    logic signed [STEP_W-1:0] position;
  } dscc_status_t;

endpackage
`default_nettype wire

// ### test_dual_stepper_command_checker.sv
`timescale 1ns/1ns
`default_nettype none
module test_dual_stepper_command_checker;
  import dscc_pkg::*;
  logic core_clk, reset, cmd_valid, hw_ready, result_valid, status_valid, sv;
  dscc_cmd_t cmd;
  dscc_switch_t switches [CHAN_N];
  logic [CODE_W-1:0] result_code, rc;
  dscc_status_t status_out;
  logic [CHAN_N-1:0] step_pulse, step_dir_cw, chan_busy, chan_ready, rdy_m;
  int pos [CHAN_N];
  int n_mismatch = 0, total_checks = 0, cycles = 0, p, op_r, sel_r;

  dscc_checker dut_u (.core_clk, .reset, .cmd_valid, .cmd, .hw_ready, .switches, .result_valid,
    .result_code, .status_valid, .status_out, .step_pulse, .step_dir_cw, .chan_busy, .chan_ready);
  dscc_motor_model #(.LIM(40)) mdl_u (.core_clk, .reset, .step_pulse, .step_dir_cw, .switches, .pos);

  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task issue(input logic signed [15:0] op, input logic [15:0] sel, input logic signed [31:0] st);
    @(negedge core_clk);
    cmd.operation_select = op;
    cmd.param[0] = sel;
    cmd.signed_step_count = st;
    cmd_valid = 1;
    @(negedge core_clk);
    // result and status strobes stand only in this cycle
    chk("result_valid", 1, result_valid);
    rc = result_code;
    sv = status_valid;
    cmd_valid = 0;
    @(negedge core_clk);
  endtask
  task wait_idle();
    for (int i = 0; i < 600 && chan_busy[0] !== 1'b0; i++) @(negedge core_clk);
    // the last pulse reaches the motor one edge after busy falls
    repeat (2) @(negedge core_clk);
  endtask
  function automatic logic [CODE_W-1:0] exp_code(input int op, input int sel, input logic [1:0] rdy);
    if (op < 0 || op > 12) return RES_BAD_OP;
    if (sel > 1) return RES_PARAM_BASE;
    if (op != 12 && rdy[sel] !== 1'b1) return sel ? RES_NOINIT_B : RES_NOINIT_A;
    return RES_OK;
  endfunction

  initial begin
    cmd_valid = 0;
    hw_ready = 1;
    reset = 1;
    cmd = '0;
    cmd.param[1] = 16'h0004;
    cmd.param[2] = 16'h0002;
    cmd.param[3] = 16'h0001;
    cmd.param[4] = 16'h0002;
    rdy_m = '0;
    void'($urandom(58436));
    repeat (16) @(negedge core_clk);
    reset = 0;
    for (int i = 0; i < 60; i++) begin
      op_r = int'($urandom_range(40)) - 15;
      if ((op_r >= 0 && op_r < 8) || op_r == 12) op_r = 8 + op_r % 4;
      sel_r = int'($urandom_range(2));
      if (i == 58) op_r = -1;
      if (i == 59) op_r = 13;
      issue(16'(op_r), 16'(sel_r), $urandom);
      chk("random code", exp_code(op_r, sel_r, rdy_m), rc);
    end
    chk("chan_ready", 0, chan_ready);
    $display("test random_checks done");
    cmd.param[1] = 16'h0001;
    issue(12, 0, 0);
    chk("init bad p1", RES_PARAM_1, rc);
    cmd.param[1] = 16'h0004;
    issue(12, 0, 0);
    chk("init a", exp_code(12, 0, rdy_m), rc);
    rdy_m[0] = 1;
    chk("chan_ready", 2'h1, chan_ready);
    issue(3, 1, 5);
    chk("b untouched", RES_NOINIT_B, rc);
    issue(0, 0, 0);
    chk("estop idle", RES_STANDSTILL, rc);
    issue(1, 0, 0);
    chk("dstop idle", RES_STANDSTILL, rc);
    hw_ready = 0;
    issue(4, 0, 3);
    chk("hw error", RES_HW_ERR, rc);
    hw_ready = 1;
    issue(4, 0, 32'sh01000000);
    chk("step high", RES_STEP_RANGE, rc);
    issue(4, 0, -32'sh01000000);
    chk("step low", RES_STEP_RANGE, rc);
    chk("busy none", 0, chan_busy);
    $display("test refusals done");
    p = pos[0];
    issue(4, 0, -3);
    chk("move", RES_OK, rc);
    issue(4, 0, -3);
    chk("busy", RES_BUSY, rc);
    chk("dir ccw", 0, step_dir_cw[0]);
    for (int i = 0; i < 200 && rc === RES_BUSY; i++) issue(4, 0, 2);
    chk("chained", RES_OK, rc);
    wait_idle();
    chk("net steps", 32'(p - 1), 32'(pos[0]));
    $display("test chain done");
    issue(4, 0, 100);
    repeat (20) @(negedge core_clk);
    issue(0, 0, 0);
    chk("estop", RES_OK, rc);
    repeat (3) @(negedge core_clk);
    chk("estop busy", 0, chan_busy[0]);
    p = pos[0];
    repeat (20) @(negedge core_clk);
    chk("estop pulses", 32'(p), 32'(pos[0]));
    $display("test estop done");
    issue(7, 0, -1);
    wait_idle();
    chk("home pos", 0, 32'(pos[0]));
    issue(3, 0, 6);
    chk("ramp", RES_OK, rc);
    wait_idle();
    chk("ramp steps", 6, 32'(pos[0]));
    issue(2, 0, -77);
    wait_idle();
    chk("jog steps", 5, 32'(pos[0]));
    for (int k = 9; k < 12; k++) begin
      issue(16'(k), 0, 0);
      chk("aux op", RES_OK, rc);
    end
    p = pos[0];
    issue(4, 0, 100);
    repeat (20) @(negedge core_clk);
    issue(1, 0, 0);
    chk("dstop", RES_OK, rc);
    wait_idle();
    issue(8, 0, 0);
    chk("dstop left", 32'(100 - (pos[0] - p)), status_out.remaining);
    issue(5, 0, 1);
    wait_idle();
    chk("inner pos", 30, 32'(pos[0]));
    $display("test home and ramp done");
    issue(6, 0, 1);
    wait_idle();
    chk("limit pos", 40, 32'(pos[0]));
    issue(8, 0, 0);
    chk("status_valid", 1, sv);
    chk("limit hit", 1, status_out.limit_hit[0]);
    chk("last op", 6, status_out.last_op);
    chk("home based", 40, status_out.position);
    $display("test limit done");
    test_done();
  end
endmodule // test_dual_stepper_command_checker
`default_nettype wire
